// [bench/adc_dac_digital_mix_control_tb.sv]
// register and mix-path test sequence for the mix control block
`timescale 1ns/1ps
module adc_dac_digital_mix_control_tb
   import adcmix_pkg::*;
;
   localparam int FDIV = 4;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, mvalid, slot, fsync;
   logic [ADDR_W-1:0] adr = '0;
   logic [3:0] sel = 4'h0;
   logic [DATA_W-1:0] wdat = '0, rdat;
   logic rst_pin_n = 1'b1, pd_n = 1'b1, valid = 1'b0, slot_en = 1'b0;
   logic [15:0] al = '0, ar = '0, d = '0, oal, oar, obl, obr;
   int bad_count = 0;
   int cmp_count = 0;
   always #5 clk_i = ~clk_i;
   adcmix_top #(.FRAME_DIV(FDIV), .CONV_PERIOD_MIN(8)) adcmix_top_inst (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .reset_pin_n_i(rst_pin_n),
      .power_down_n_i(pd_n), .slot_input_i(slot), .serial_frame_sync_o(fsync), .adc_valid_i(valid),
      .adc_left_i(al), .adc_right_i(ar), .dac_a_left_i(d), .dac_a_right_i(d), .dac_b_left_i(d),
      .dac_b_right_i(d), .dac_mix_valid_o(mvalid), .dac_a_left_o(oal), .dac_a_right_o(oar),
      .dac_b_left_o(obl), .dac_b_right_o(obr));
   adcmix_dsp_model #(.PERIOD(5)) adcmix_dsp_model_inst (
      .clk_i(clk_i), .rst_i(rst_i), .en_i(slot_en), .slot_input_o(slot));
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one classic cycle; request held until ack is sampled high
   task automatic wb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] v, output logic [31:0] r);
      int n;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= 4'h3;
      wdat <= v;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      r = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      // a missing ack counts as a mismatch and ends the run
      if (ack !== 1'b1) begin
         bad_count++;
         close_out();
      end
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] v);
      logic [31:0] r;
      wb(1'b1, a, v, r);
   endtask
   task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
      logic [31:0] r;
      wb(1'b0, a, 32'h0, r);
      chk(r, exp);
   endtask
   function automatic logic [15:0] expo(input logic [15:0] dv, av, input logic m, input logic [5:0] k);
      logic [15:0] mant;
      logic signed [31:0] c;
      logic signed [31:0] s;
      mant = (k[1:0] == 0) ? MANT_0DB : (k[1:0] == 1) ? MANT_1P5DB : (k[1:0] == 2) ? MANT_3DB : MANT_4P5DB;
      c = ($signed(av) * $signed({1'b0, mant})) >>> (MANT_FRAC + k[5:2]);
      if (m || k == ATTEN_FULL_MUTE) c = 0;
      s = $signed(dv) + c;
      if (s > 32767) s = 32767;
      else if (s < -32768) s = -32768;
      return s[15:0];
   endfunction
   task automatic conv(input int gap);
      @(posedge clk_i);
      // one strobe times the adc and both dac pairs, so all share one generator
      valid <= 1'b1;
      @(posedge clk_i);
      valid <= 1'b0;
      #1;
      chk(mvalid, 1'b1);
      repeat (gap) @(posedge clk_i);
   endtask
   task automatic mix_check(input logic [15:0] ra, rb, a_l, a_r, dv);
      wr(ADDR_MIX_A, ra);
      wr(ADDR_MIX_B, rb);
      al <= a_l;
      ar <= a_r;
      d <= dv;
      conv(2);
      chk(oal, expo(dv, a_l, ra[15], ra[13:8]));
      chk(oar, expo(dv, a_r, ra[7], ra[5:0]));
      chk(obl, expo(dv, a_l, rb[15], rb[13:8]));
      chk(obr, expo(dv, a_r, rb[7], rb[5:0]));
   endtask
   initial begin
      int n;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      // pin synchronisers need a few cycles before writes land
      repeat (4) @(posedge clk_i);
      rd_chk(ADDR_MIX_A, 32'h8080);
      rd_chk(ADDR_MIX_B, 32'h8080);
      rd_chk(8'h40, 32'h0);
      wr(8'h40, 32'h5555);
      wr(ADDR_MIX_A, 32'hbfbf);
      rd_chk(ADDR_MIX_A, 32'hbfbf);
      wr(ADDR_MIX_B, 32'h3f3f);
      rd_chk(ADDR_MIX_B, 32'h3f3f);
      mix_check(16'h0000, 16'h0101, 16'h4000, 16'hc000, 16'h0100);
      mix_check(16'h0480, 16'h3e3f, 16'h4000, 16'hc001, 16'h0000);
      mix_check(16'h8080, 16'h0000, 16'h1234, 16'hedcc, 16'h0000);
      mix_check(16'h0203, 16'h8002, 16'h7fff, 16'h8000, 16'h0010);
      mix_check(16'h0000, 16'h0000, 16'h4000, 16'h8000, 16'h7000);
      mix_check(16'h0000, 16'h0000, 16'hc000, 16'h8000, 16'h9000);
      for (int i = 0; i < 3; i++) begin
         wr(ADDR_MIX_A, 32'h1234);
         wr(ADDR_MIX_B, 32'h0a05);
         if (i == 0) wr(ADDR_CTRL, 32'h1);
         else if (i == 1) pd_n <= 1'b0;
         else rst_pin_n <= 1'b0;
         repeat (4) @(posedge clk_i);
         // rate fault from the mix runs still stands beside the lock
         rd_chk(ADDR_STAT, 32'h3);
         rd_chk(ADDR_MIX_A, 32'h8080);
         wr(ADDR_MIX_A, 32'h0101);
         wr(ADDR_MIX_B, 32'h0101);
         rd_chk(ADDR_MIX_B, 32'h8080);
         wr(ADDR_CTRL, 32'h0);
         pd_n <= 1'b1;
         rst_pin_n <= 1'b1;
         repeat (4) @(posedge clk_i);
         rd_chk(ADDR_MIX_A, 32'h8080);
      end
      // slave mode, no frames: conversions outrun the link
      wr(ADDR_STAT, 32'h2);
      conv(12);
      conv(12);
      rd_chk(ADDR_STAT, 32'h2);
      wr(ADDR_STAT, 32'h2);
      rd_chk(ADDR_STAT, 32'h0);
      n = 0;
      repeat (16) begin
         @(posedge clk_i);
         if (fsync !== 1'b0) n++;
      end
      chk(n, 0);
      slot_en <= 1'b1;
      repeat (12) @(posedge clk_i);
      wr(ADDR_STAT, 32'h2);
      conv(12);
      conv(12);
      rd_chk(ADDR_STAT, 32'h0);
      slot_en <= 1'b0;
      wr(ADDR_CTRL, 32'h2);
      n = 0;
      while (fsync !== 1'b1 && n < 50) begin
         @(posedge clk_i);
         n++;
      end
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (fsync !== 1'b1 && n < 50);
      chk(n, FDIV);
      wr(ADDR_STAT, 32'h2);
      conv(12);
      conv(12);
      rd_chk(ADDR_STAT, 32'h0);
      close_out();
   end
endmodule

// [bench/adcmix_dsp_model.sv]
// slot-input source standing in for the serial-port host
`timescale 1ns/1ps
module adcmix_dsp_model #(
   parameter int PERIOD = 5
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic en_i,
   output logic slot_input_o
);
   int cnt;
   always_ff @(posedge clk_i) begin
      if (rst_i || !en_i) begin
         cnt <= 0;
         // line stands still outside frames
         slot_input_o <= 1'b0;
      end else begin
         cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
         slot_input_o <= (cnt == 0);
      end
   end
endmodule

// [hw/adcmix_path.sv]
// one attenuated adc-into-dac mix path with saturation
`timescale 1ns/1ps
module adcmix_path
   import adcmix_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   adcmix_path_if.path p
);
   logic [15:0] mant;
   logic signed [32:0] prod;
   logic signed [32:0] scaled;
   logic signed [15:0] contrib;
   logic signed [16:0] sum;
   logic signed [15:0] mix_q;
   logic signed [15:0] next_mix;

   always_comb begin
      unique case (p.atten[1:0])
         2'h0: mant = MANT_0DB;
         2'h1: mant = MANT_1P5DB;
         2'h2: mant = MANT_3DB;
         2'h3: mant = MANT_4P5DB;
      endcase
      prod = $signed(p.adc) * $signed({1'b0, mant});
      // 6 dB per shift instead of 6.02 dB; error grows to about 0.3 dB at the deep end
      scaled = prod >>> (MANT_FRAC + int'(p.atten[5:2]));
      if (p.mute || p.atten == ATTEN_FULL_MUTE) begin
         contrib = 16'sh0000;
      end else begin
         contrib = scaled[15:0];
      end
      sum = {p.dac_in[15], p.dac_in} + {contrib[15], contrib};
      if (sum[16] != sum[15]) begin
         next_mix = sum[16] ? 16'sh8000 : 16'sh7fff;
      end else begin
         next_mix = sum[15:0];
      end
      if (!p.valid) begin
         next_mix = mix_q;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mix_q <= 16'sh0000;
      end else begin
         mix_q <= next_mix;
      end
   end

   assign p.mix_out = mix_q;

   a_mute_passes_dac: assert property (@(posedge clk_i) disable iff (rst_i)
      p.valid && p.mute |=> p.mix_out == $past(p.dac_in)) else $error("muted path altered dac input");
   a_full_mute_code: assert property (@(posedge clk_i) disable iff (rst_i)
      p.valid && p.atten == 6'h3f |=> p.mix_out == $past(p.dac_in)) else $error("code 3f did not mute");
   a_zero_atten_unity: assert property (@(posedge clk_i) disable iff (rst_i)
      p.valid && !p.mute && p.atten == 6'h00 && p.dac_in == 16'sh0000 |=> p.mix_out == $past(p.adc))
      else $error("0 dB code changed adc level");
   a_four_steps_half: assert property (@(posedge clk_i) disable iff (rst_i)
      p.valid && !p.mute && p.atten == 6'h04 && p.dac_in == 16'sh0000 |=> p.mix_out == ($past(p.adc) >>> 1))
      else $error("6 dB step wrong");
   c_path_mixing: cover property (@(posedge clk_i) disable iff (rst_i) p.valid && !p.mute && p.atten == 6'h02);
endmodule

// [hw/adcmix_top.sv]
// adc-to-dac digital mix control register bank with wishbone slave and mix paths
// Summary of operation
// - mix register a: mutes 15,7; attenuation 13:8,5:0
// - left mute clear adds attenuated left adc
// - right mute clear adds attenuated right adc
// - mix register b same layout, second dac
// - each attenuation step adds 1.5 dB
// - attenuation code zero passes at 0 dB
// - code 3e is 93 dB, 3f mutes
// - mix register a resets to 8080
// - reset or power-down pin holds default, blocks writes
// - conversions-off bit holds default, blocks writes
// - frame rate at least the conversion rate
// - as master, frame sync not slower than conversions
// - mix register b resets 8080, acts like a
//
// Local design decision: the Wishbone register port.
`timescale 1ns/1ps
module adcmix_top
   import adcmix_pkg::*;
#(
   parameter int FRAME_DIV = FRAME_DIV_DEF,
   parameter int CONV_PERIOD_MIN = CONV_PERIOD_MIN_DEF
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADDR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [DATA_W-1:0] wb_dat_i,
   output logic [DATA_W-1:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic reset_pin_n_i,
   input wire logic power_down_n_i,
   input wire logic slot_input_i,
   output logic serial_frame_sync_o,
   input wire logic adc_valid_i,
   input wire logic [15:0] adc_left_i,
   input wire logic [15:0] adc_right_i,
   input wire logic [15:0] dac_a_left_i,
   input wire logic [15:0] dac_a_right_i,
   input wire logic [15:0] dac_b_left_i,
   input wire logic [15:0] dac_b_right_i,
   output logic dac_mix_valid_o,
   output logic [15:0] dac_a_left_o,
   output logic [15:0] dac_a_right_o,
   output logic [15:0] dac_b_left_o,
   output logic [15:0] dac_b_right_o
);
   localparam int FRAME_CNT_W = $clog2(FRAME_DIV);

   // refused at elaboration: the monitor cannot serve such a divider
   if (FRAME_DIV < 2 || FRAME_DIV > CONV_PERIOD_MIN) begin : g_bad_frame_div
      $error("frame divider must lie between 2 and the shortest conversion period");
   end

   // pin synchronisers; stage one is read only by stage two
   logic [1:0] rst_pin_sync;
   logic [1:0] pdn_sync;
   logic [2:0] slot_sync;
   logic [1:0] next_rst_pin_sync;
   logic [1:0] next_pdn_sync;
   logic [2:0] next_slot_sync;

   always_comb begin
      next_rst_pin_sync = {rst_pin_sync[0], reset_pin_n_i};
      next_pdn_sync = {pdn_sync[0], power_down_n_i};
      next_slot_sync = {slot_sync[1:0], slot_input_i};
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rst_pin_sync <= 2'h0;
         pdn_sync <= 2'h0;
         slot_sync <= 3'h0;
      end else begin
         rst_pin_sync <= next_rst_pin_sync;
         pdn_sync <= next_pdn_sync;
         slot_sync <= next_slot_sync;
      end
   end

   // register state
   logic [1:0] ctrl;
   logic [REG_W-1:0] mix_a;
   logic [REG_W-1:0] mix_b;
   logic rate_fault;
   logic ack;
   logic [DATA_W-1:0] rdata;
   logic [1:0] next_ctrl;
   logic [REG_W-1:0] next_mix_a;
   logic [REG_W-1:0] next_mix_b;
   logic next_rate_fault;
   logic next_ack;
   logic [DATA_W-1:0] next_rdata;

   logic locked;
   logic req;
   logic wr;
   logic [REG_W-1:0] lane_mask;
   logic frame_event;
   logic seen_frame;
   logic next_seen_frame;
   logic rate_miss;

   // locked while reset pin low, power-down pin low, or conversions off
   assign locked = !rst_pin_sync[1] || !pdn_sync[1] || ctrl[CTRL_CONV_OFF_BIT];
   assign req = wb_cyc_i && wb_stb_i && !ack;
   assign wr = req && wb_we_i;
   assign lane_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}} & MIX_WMASK;

   always_comb begin
      next_ack = req;
      next_ctrl = ctrl;
      next_mix_a = mix_a;
      next_mix_b = mix_b;
      next_rdata = 32'h0000_0000;
      next_rate_fault = rate_fault;
      if (wr && wb_adr_i == ADDR_CTRL && wb_sel_i[0]) begin
         next_ctrl = wb_dat_i[1:0];
      end
      if (wr && wb_adr_i == ADDR_MIX_A) begin
         next_mix_a = (mix_a & ~lane_mask) | (wb_dat_i[REG_W-1:0] & lane_mask);
      end
      if (wr && wb_adr_i == ADDR_MIX_B) begin
         next_mix_b = (mix_b & ~lane_mask) | (wb_dat_i[REG_W-1:0] & lane_mask);
      end
      // write one clears; a miss in the same cycle wins
      if (wr && wb_adr_i == ADDR_STAT && wb_sel_i[0] && wb_dat_i[STAT_RATE_FAULT_BIT]) begin
         next_rate_fault = 1'b0;
      end
      if (rate_miss) begin
         next_rate_fault = 1'b1;
      end
      // the lock overrides any mix register write in the same cycle
      if (locked) begin
         next_mix_a = MIX_RESET;
         next_mix_b = MIX_RESET;
      end
      if (req && !wb_we_i) begin
         unique case (wb_adr_i)
            ADDR_CTRL: next_rdata = {30'h0000_0000, ctrl};
            ADDR_STAT: next_rdata = {30'h0000_0000, rate_fault, locked};
            ADDR_MIX_A: next_rdata = {16'h0000, mix_a};
            ADDR_MIX_B: next_rdata = {16'h0000, mix_b};
            default: next_rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack <= 1'b0;
         ctrl <= CTRL_RESET;
         mix_a <= MIX_RESET;
         mix_b <= MIX_RESET;
         rdata <= 32'h0000_0000;
         rate_fault <= 1'b0;
      end else begin
         ack <= next_ack;
         ctrl <= next_ctrl;
         mix_a <= next_mix_a;
         mix_b <= next_mix_b;
         rdata <= next_rdata;
         rate_fault <= next_rate_fault;
      end
   end

   assign wb_ack_o = ack;
   assign wb_dat_o = rdata;

   // frame sync generator and frame-rate monitor
   logic [FRAME_CNT_W-1:0] frame_cnt;
   logic [FRAME_CNT_W-1:0] next_frame_cnt;
   logic fsync;
   logic next_fsync;
   logic mix_valid;
   logic next_mix_valid;

   localparam logic [FRAME_CNT_W-1:0] FRAME_LAST = FRAME_CNT_W'(FRAME_DIV - 1);

   always_comb begin
      next_frame_cnt = frame_cnt;
      next_fsync = 1'b0;
      if (ctrl[CTRL_MASTER_BIT]) begin
         if (frame_cnt == FRAME_LAST) begin
            next_frame_cnt = '0;
            next_fsync = 1'b1;
         end else begin
            next_frame_cnt = frame_cnt + 1'b1;
         end
      end else begin
         next_frame_cnt = '0;
      end
      next_mix_valid = adc_valid_i;
   end

   // slave frames come from the partner's slot input edges
   assign frame_event = ctrl[CTRL_MASTER_BIT] ? fsync : (slot_sync[1] && !slot_sync[2]);
   // monitor judges from conversion to conversion; only a conversion with no frame since the last one exposes a slow link
   assign rate_miss = adc_valid_i && !seen_frame && !frame_event && !locked;

   always_comb begin
      next_seen_frame = seen_frame;
      if (adc_valid_i) begin
         next_seen_frame = 1'b0;
      end
      if (frame_event) begin
         next_seen_frame = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         frame_cnt <= '0;
         fsync <= 1'b0;
         seen_frame <= 1'b1;
         mix_valid <= 1'b0;
      end else begin
         frame_cnt <= next_frame_cnt;
         fsync <= next_fsync;
         seen_frame <= next_seen_frame;
         mix_valid <= next_mix_valid;
      end
   end

   assign serial_frame_sync_o = fsync;
   assign dac_mix_valid_o = mix_valid;

   // four mix paths: index bit 1 picks dac pair, bit 0 picks right side
   logic [15:0] dac_in_arr [4];
   logic [15:0] mix_arr [4];
   assign dac_in_arr[0] = dac_a_left_i;
   assign dac_in_arr[1] = dac_a_right_i;
   assign dac_in_arr[2] = dac_b_left_i;
   assign dac_in_arr[3] = dac_b_right_i;

   for (genvar i = 0; i < 4; i++) begin : g_path
      adcmix_path_if pif ();
      logic [REG_W-1:0] mreg;
      assign mreg = (i < 2) ? mix_a : mix_b;
      assign pif.valid = adc_valid_i;
      assign pif.adc = (i % 2 == 0) ? adc_left_i : adc_right_i;
      assign pif.dac_in = dac_in_arr[i];
      assign pif.mute = (i % 2 == 0) ? mreg[LEFT_MUTE_BIT] : mreg[RIGHT_MUTE_BIT];
      assign pif.atten = (i % 2 == 0) ? mreg[LEFT_ATTEN_LSB +: ATTEN_W] : mreg[RIGHT_ATTEN_LSB +: ATTEN_W];
      assign mix_arr[i] = pif.mix_out;
      adcmix_path adcmix_path_inst (
         .clk_i(clk_i),
         .rst_i(rst_i),
         .p(pif.path)
      );
   end

   assign dac_a_left_o = mix_arr[0];
   assign dac_a_right_o = mix_arr[1];
   assign dac_b_left_o = mix_arr[2];
   assign dac_b_right_o = mix_arr[3];

   a_reset_value_a: assert property (@(posedge clk_i)
      $past(rst_i) |-> mix_a == 16'h8080 && mix_b == 16'h8080) else $error("mix registers not 8080 after reset");
   a_lock_holds_default: assert property (@(posedge clk_i) disable iff (rst_i)
      locked |=> mix_a == 16'h8080 && mix_b == 16'h8080) else $error("locked mix register not at default");
   a_conv_off_blocks: assert property (@(posedge clk_i) disable iff (rst_i)
      ctrl[0] && wr && wb_adr_i == ADDR_MIX_A |=> mix_a == 16'h8080) else $error("write got through while off");
   a_reserved_read_zero: assert property (@(posedge clk_i) disable iff (rst_i)
      mix_a[14] == 1'b0 && mix_a[6] == 1'b0 && mix_b[14] == 1'b0 && mix_b[6] == 1'b0)
      else $error("reserved bit set");
   a_write_lands: assert property (@(posedge clk_i) disable iff (rst_i)
      wr && !locked && wb_adr_i == ADDR_MIX_B && wb_sel_i[1:0] == 2'h3
      |=> mix_b == ($past(wb_dat_i[15:0]) & 16'hbfbf) || locked) else $error("mix b write lost");
   a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
   a_frame_spacing: assert property (@(posedge clk_i) disable iff (rst_i)
      fsync && ctrl[1] |=> !fsync [*2]) else $error("frame sync too dense");
   a_miss_flags: assert property (@(posedge clk_i) disable iff (rst_i)
      rate_miss |=> rate_fault) else $error("frame miss not flagged");
   c_mix_write: cover property (@(posedge clk_i) disable iff (rst_i) wr && !locked && wb_adr_i == ADDR_MIX_A);
   c_locked_write: cover property (@(posedge clk_i) disable iff (rst_i) wr && locked && wb_adr_i == ADDR_MIX_B);
   c_rate_fault: cover property (@(posedge clk_i) disable iff (rst_i) rate_miss);
endmodule

// [include/adcmix_path_if.sv]
// signals between the register bank and one mix path
`timescale 1ns/1ps
interface adcmix_path_if;
   logic valid;
   logic signed [15:0] adc;
   logic signed [15:0] dac_in;
   logic mute;
   logic [5:0] atten;
   logic signed [15:0] mix_out;
   modport path (input valid, input adc, input dac_in, input mute, input atten, output mix_out);
   modport ctrl (output valid, output adc, output dac_in, output mute, output atten, input mix_out);
endinterface

// [include/adcmix_pkg.sv]
// constants and register layout of the adc-to-dac digital mix control block
package adcmix_pkg;
   localparam int CLK_MHZ = 100;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int REG_W = 16;
   // register indices; byte address is four times the index
   localparam logic [5:0] REG_CTRL_IDX = 6'h00;
   localparam logic [5:0] REG_STAT_IDX = 6'h01;
   localparam logic [5:0] REG_MIX_A_IDX = 6'h0d;
   localparam logic [5:0] REG_MIX_B_IDX = 6'h0e;
   localparam logic [ADDR_W-1:0] ADDR_CTRL = {REG_CTRL_IDX, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_STAT = {REG_STAT_IDX, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_MIX_A = {REG_MIX_A_IDX, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_MIX_B = {REG_MIX_B_IDX, 2'b00};
   // mix register fields
   localparam int LEFT_MUTE_BIT = 15;
   localparam int LEFT_RES_BIT = 14;
   localparam int LEFT_ATTEN_LSB = 8;
   localparam int RIGHT_MUTE_BIT = 7;
   localparam int RIGHT_RES_BIT = 6;
   localparam int RIGHT_ATTEN_LSB = 0;
   localparam int ATTEN_W = 6;
   localparam logic [REG_W-1:0] MIX_RESET = 16'h8080;
   localparam logic [REG_W-1:0] MIX_WMASK = 16'hbfbf;
   localparam logic [ATTEN_W-1:0] ATTEN_FULL_MUTE = 6'h3f;
   // control and status fields
   localparam int CTRL_CONV_OFF_BIT = 0;
   localparam int CTRL_MASTER_BIT = 1;
   localparam logic [1:0] CTRL_RESET = 2'h0;
   localparam int STAT_LOCK_BIT = 0;
   localparam int STAT_RATE_FAULT_BIT = 1;
   // gain of one 1.5 dB step group, q15; four steps make one 6 dB shift
   localparam int MANT_FRAC = 15;
   localparam logic [15:0] MANT_0DB = 16'h8000;
   localparam logic [15:0] MANT_1P5DB = 16'h6bb3;
   localparam logic [15:0] MANT_3DB = 16'h5a9d;
   localparam logic [15:0] MANT_4P5DB = 16'h4c40;
   // frame sync divider default in clock cycles
   localparam int FRAME_DIV_DEF = 256;
   localparam int CONV_PERIOD_MIN_DEF = 1024;
endpackage
